// ===== hw/sdsw_pkg.sv
// Purpose: Shared constants for the station detect status word block
// Assumes: 16-bit status word, 8-bit internal memory word address space
// Notes: Register offsets are word indices on the plain register port
package sdsw_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    localparam int MEM_AW = 8;
    // Register port offsets
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CFG = 8'h01;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h02;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h03;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_MEM_ADDR = 8'h05;
    localparam logic [ADDR_W-1:0] REG_MEM_DATA = 8'h06;
    // Status word field positions
    localparam int BIT_BOARD_ERR = 15;
    localparam int BIT_HOST_ERR = 14;
    localparam int STN_LSB = 0;
    localparam int STN_W = 4;
    localparam logic [3:0] STN_NONE = 4'h0;
    // Configuration register fields
    localparam int CFG_ADDR_LSB = 0;
    localparam int CFG_AREA_LSB = 8;
    localparam int CFG_BITSEL = 10;
    localparam int CFG_VALID = 15;
    localparam logic [WORD_W-1:0] CFG_RESET = 16'h0000;
    // Memory areas
    localparam logic [1:0] AREA_GENERAL = 2'h0;
    localparam logic [1:0] AREA_HELD = 2'h1;
    localparam logic [1:0] AREA_SYSTEM = 2'h2;
    // Flag register fields
    localparam int FLG_BOARD = 0;
    localparam int FLG_HOST = 1;
    // Interrupt status bits
    localparam int IRQ_STN_CHG = 0;
    localparam int IRQ_BOARD = 1;
    localparam int IRQ_HOST = 2;
    localparam int IRQ_CFG_REJ = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
    localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
endpackage

// ===== hw/sdsw_word_mem.sv
// Purpose: Small two-port word memory for one internal memory area
// Assumes: One write and one read port, read data registered
// Notes: Contents are not cleared by reset
`timescale 1ns/1ps
module sdsw_word_mem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule // sdsw_word_mem

// ===== hw/sdsw_line_sync.sv
// Purpose: Two-stage capture and change detect for the station lines
// Assumes: Lines are synchronous to mclk_i
// Notes: Change pulse compares the settled stages only
`timescale 1ns/1ps
module sdsw_line_sync #(
    parameter int W = 4
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] lines_i,
    output logic [W-1:0] lines_o,
    output logic change_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= lines_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lines_o = s2_q;
    assign change_o = (s2_q != s3_q);
endmodule // sdsw_line_sync

// ===== hw/sdsw_top.sv
// Purpose: Station detect status word: samples station lines, packs status word, stores it
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Word is rewritten into the chosen memory area every clock once configured
//        Interrupt status bits are sticky and clear when their register is read
//        Memory contents survive reset; the location and the memory read address are forgotten
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module sdsw_top #(
    parameter int MEM_AW = sdsw_pkg::MEM_AW
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic station_line_one_i,
    input wire logic station_line_two_i,
    input wire logic station_line_three_i,
    input wire logic station_line_four_i,
    input wire logic board_fault_i,
    input wire logic host_comm_err_i,
    input wire logic [sdsw_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [sdsw_pkg::WORD_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [sdsw_pkg::WORD_W-1:0] reg_rdata_o,
    output logic box_present_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [sdsw_pkg::WORD_W-1:0] pack_word(
        input logic [3:0] stn,
        input logic board,
        input logic host
    );
        logic [sdsw_pkg::WORD_W-1:0] w;
        w = sdsw_pkg::ZERO_WORD;
        w[sdsw_pkg::STN_LSB +: sdsw_pkg::STN_W] = stn;
        w[sdsw_pkg::BIT_BOARD_ERR] = board;
        w[sdsw_pkg::BIT_HOST_ERR] = host;
        return w;
    endfunction

    function automatic logic cfg_ok(input logic [sdsw_pkg::WORD_W-1:0] c);
        logic ok;
        ok = c[sdsw_pkg::CFG_VALID];
        if (c[sdsw_pkg::CFG_BITSEL]) begin
            ok = 1'b0;
        end
        if (c[sdsw_pkg::CFG_AREA_LSB +: 2] != sdsw_pkg::AREA_GENERAL &&
            c[sdsw_pkg::CFG_AREA_LSB +: 2] != sdsw_pkg::AREA_HELD) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic reg_hit(
        input logic [sdsw_pkg::ADDR_W-1:0] a,
        input logic [sdsw_pkg::ADDR_W-1:0] off
    );
        return a == off;
    endfunction

    // Interrupt bits sit at the bottom of a read word
    function automatic logic [sdsw_pkg::WORD_W-1:0] irq_word(
        input logic [sdsw_pkg::IRQ_W-1:0] v
    );
        logic [sdsw_pkg::WORD_W-1:0] w;
        w = sdsw_pkg::ZERO_WORD;
        w[sdsw_pkg::IRQ_W-1:0] = v;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Station line capture

    logic [3:0] raw_lines;
    logic [3:0] stn_lines;
    logic stn_change;

    // Status lags the lines by three edges: two capture stages and the word
    // Line one weight one, line four weight eight; ON level reads as 1
    assign raw_lines = {station_line_four_i, station_line_three_i,
                        station_line_two_i, station_line_one_i};

    sdsw_line_sync #(
        .W(sdsw_pkg::STN_W)
    ) u_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .lines_i(raw_lines),
        .lines_o(stn_lines),
        .change_o(stn_change)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status word

    logic [sdsw_pkg::WORD_W-1:0] status_q;
    logic board_q;
    logic host_q;
    logic [sdsw_pkg::WORD_W-1:0] status_d;

    assign status_d = pack_word(stn_lines, board_q, host_q);

    // Error inputs are captured once so word and flags agree
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            board_q <= 1'b0;
            host_q <= 1'b0;
        end else begin
            board_q <= board_fault_i;
            host_q <= host_comm_err_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            status_q <= sdsw_pkg::ZERO_WORD;
        end else begin
            status_q <= status_d;
        end
    end

    logic [sdsw_pkg::STN_W-1:0] stn_field;

    assign stn_field = status_q[sdsw_pkg::STN_LSB +: sdsw_pkg::STN_W];
    assign box_present_o = (stn_field != sdsw_pkg::STN_NONE);

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic sel_status;
    logic sel_cfg;
    logic sel_flags;
    logic sel_istat;
    logic sel_imask;
    logic sel_maddr;
    logic sel_mdata;

    // Whole index compare; unmapped indices match nothing and read zero
    assign sel_status = reg_hit(reg_addr_i, sdsw_pkg::REG_STATUS);
    assign sel_cfg = reg_hit(reg_addr_i, sdsw_pkg::REG_CFG);
    assign sel_flags = reg_hit(reg_addr_i, sdsw_pkg::REG_FLAGS);
    assign sel_istat = reg_hit(reg_addr_i, sdsw_pkg::REG_IRQ_STAT);
    assign sel_imask = reg_hit(reg_addr_i, sdsw_pkg::REG_IRQ_MASK);
    assign sel_maddr = reg_hit(reg_addr_i, sdsw_pkg::REG_MEM_ADDR);
    assign sel_mdata = reg_hit(reg_addr_i, sdsw_pkg::REG_MEM_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Location configuration

    logic [sdsw_pkg::WORD_W-1:0] cfg_q;
    logic cfg_wr;
    logic cfg_accept;
    logic cfg_reject;

    logic cfg_req_valid;
    logic cfg_good;
    logic cfg_clear;

    assign cfg_wr = reg_wr_i && sel_cfg;
    assign cfg_req_valid = reg_wdata_i[sdsw_pkg::CFG_VALID];
    assign cfg_good = cfg_ok(reg_wdata_i);
    assign cfg_accept = cfg_wr && cfg_good;
    // A refused request leaves the old location in force
    assign cfg_reject = cfg_wr && cfg_req_valid && !cfg_good;
    // Clearing the valid bit always unassigns the location
    assign cfg_clear = cfg_wr && !cfg_req_valid;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cfg_q <= sdsw_pkg::CFG_RESET;
        end else if (cfg_accept) begin
            cfg_q <= reg_wdata_i;
        end else if (cfg_clear) begin
            cfg_q <= sdsw_pkg::CFG_RESET;
        end
    end

    logic cfg_valid;
    logic [1:0] cfg_area;
    logic [MEM_AW-1:0] cfg_addr;

    assign cfg_valid = cfg_q[sdsw_pkg::CFG_VALID];
    assign cfg_area = cfg_q[sdsw_pkg::CFG_AREA_LSB +: 2];
    assign cfg_addr = cfg_q[sdsw_pkg::CFG_ADDR_LSB +: MEM_AW];

    ////////////////////////////////////////////////////////////////////////////
    // Internal memory areas

    logic [sdsw_pkg::WORD_W-1:0] maddr_q;
    logic [MEM_AW-1:0] rd_addr;
    logic rd_area;
    logic gen_we;
    logic held_we;
    logic [sdsw_pkg::WORD_W-1:0] gen_rdata;
    logic [sdsw_pkg::WORD_W-1:0] held_rdata;

    logic [MEM_AW-1:0] wr_addr;
    logic [sdsw_pkg::WORD_W-1:0] wr_word;

    // Reporting inactive until a word address is assigned
    assign gen_we = cfg_valid && (cfg_area == sdsw_pkg::AREA_GENERAL);
    assign held_we = cfg_valid && (cfg_area == sdsw_pkg::AREA_HELD);
    // Both areas share one write address; only the chosen one is enabled
    assign wr_addr = cfg_addr;
    assign wr_word = status_q;
    assign rd_addr = maddr_q[MEM_AW-1:0];
    assign rd_area = maddr_q[sdsw_pkg::CFG_AREA_LSB];

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            maddr_q <= sdsw_pkg::ZERO_WORD;
        end else if (reg_wr_i && sel_maddr) begin
            maddr_q <= reg_wdata_i;
        end
    end

    sdsw_word_mem #(
        .AW(MEM_AW),
        .DW(sdsw_pkg::WORD_W)
    ) u_gen_mem (
        .mclk_i(mclk_i),
        .we_i(gen_we),
        .waddr_i(wr_addr),
        .wdata_i(wr_word),
        .raddr_i(rd_addr),
        .rdata_o(gen_rdata)
    );

    sdsw_word_mem #(
        .AW(MEM_AW),
        .DW(sdsw_pkg::WORD_W)
    ) u_held_mem (
        .mclk_i(mclk_i),
        .we_i(held_we),
        .waddr_i(wr_addr),
        .wdata_i(wr_word),
        .raddr_i(rd_addr),
        .rdata_o(held_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    logic [sdsw_pkg::IRQ_W-1:0] istat_q;
    logic [sdsw_pkg::IRQ_W-1:0] imask_q;
    logic [sdsw_pkg::IRQ_W-1:0] ievt;
    logic istat_clr;
    logic board_rise;
    logic host_rise;

    assign board_rise = board_q && !status_q[sdsw_pkg::BIT_BOARD_ERR];
    assign host_rise = host_q && !status_q[sdsw_pkg::BIT_HOST_ERR];
    logic [sdsw_pkg::IRQ_W-1:0] istat_d;
    logic imask_wr;

    // Events: station change, board rise, host rise, refused location
    assign ievt = {cfg_reject, host_rise, board_rise, stn_change};
    assign istat_clr = reg_rd_i && sel_istat;
    // New events win over the read clear
    assign istat_d = (istat_clr ? sdsw_pkg::IRQ_RESET : istat_q) | ievt;
    assign imask_wr = reg_wr_i && sel_imask;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            istat_q <= sdsw_pkg::IRQ_RESET;
        end else begin
            istat_q <= istat_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            imask_q <= sdsw_pkg::MASK_RESET;
        end else if (imask_wr) begin
            imask_q <= reg_wdata_i[sdsw_pkg::IRQ_W-1:0];
        end
    end

    assign irq_o = |(istat_q & imask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [sdsw_pkg::WORD_W-1:0] rd_mux;
    logic [sdsw_pkg::WORD_W-1:0] flags_word;
    logic mdata_rd_q;
    logic mdata_area_q;
    logic [sdsw_pkg::WORD_W-1:0] rdata_q;

    assign flags_word = {{(sdsw_pkg::WORD_W-2){1'b0}}, host_q, board_q};

    logic [sdsw_pkg::WORD_W-1:0] rdata_d;
    logic mdata_rd;

    assign rd_mux = sel_status ? status_q :
                    sel_cfg ? cfg_q :
                    sel_flags ? flags_word :
                    sel_istat ? irq_word(istat_q) :
                    sel_imask ? irq_word(imask_q) :
                    sel_maddr ? maddr_q :
                    sdsw_pkg::ZERO_WORD;
    // Read data stand for one cycle only and are zero otherwise
    assign rdata_d = reg_rd_i ? rd_mux : sdsw_pkg::ZERO_WORD;
    assign mdata_rd = reg_rd_i && sel_mdata;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_q <= sdsw_pkg::ZERO_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            mdata_rd_q <= 1'b0;
        end else begin
            mdata_rd_q <= mdata_rd;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            mdata_area_q <= 1'b0;
        end else begin
            mdata_area_q <= rd_area;
        end
    end

    // Memory data come from the memory's own output register
    assign reg_rdata_o = mdata_rd_q ? (mdata_area_q ? held_rdata : gen_rdata) : rdata_q;
endmodule // sdsw_top

// ===== tb/sdsw_assertions.sv
// Purpose: Port checks for the status word block
// Assumes: One clock, synchronous active-low reset
// Notes: calm marks inputs steady long enough to reach the word
`timescale 1ns/1ps
module sdsw_assertions (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic station_line_one_i,
    input wire logic station_line_two_i,
    input wire logic station_line_three_i,
    input wire logic station_line_four_i,
    input wire logic board_fault_i,
    input wire logic host_comm_err_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic box_present_o,
    input wire logic irq_o
);
    wire logic [3:0] stn = {station_line_four_i, station_line_three_i,
        station_line_two_i, station_line_one_i};
    wire logic [1:0] flg = {host_comm_err_i, board_fault_i};
    logic [3:0] stn_q;
    logic [1:0] flg_q;
    logic [2:0] age_q;
    wire logic calm = age_q >= 3'h5 && stn == stn_q && flg == flg_q;
    wire logic rd_st = reg_rd_i && reg_addr_i == sdsw_pkg::REG_STATUS;
    wire logic rd_cfg = reg_rd_i && reg_addr_i == sdsw_pkg::REG_CFG;
    always_ff @(posedge mclk_i) begin
        stn_q <= stn;
        flg_q <= flg;
        if (!rstn_i || stn != stn_q || flg != flg_q) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////
    property p_stn; rd_st && calm |=> reg_rdata_o[3:0] == $past(stn); endproperty
    a_stn: assert property (p_stn) else $error("station field wrong");
    property p_box; calm |-> box_present_o == (stn != 4'h0); endproperty
    a_box: assert property (p_box) else $error("box detect wrong");
    property p_brd; rd_st && calm |=> reg_rdata_o[15] == $past(flg[0]); endproperty
    a_brd: assert property (p_brd) else $error("board bit wrong");
    property p_hst; rd_st && calm |=> reg_rdata_o[14] == $past(flg[1]); endproperty
    a_hst: assert property (p_hst) else $error("host bit wrong");
    property p_rsv; rd_st |=> reg_rdata_o[13:4] == 10'h000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_bit; rd_cfg |=> !(reg_rdata_o[15] && reg_rdata_o[10]); endproperty
    a_bit: assert property (p_bit) else $error("bit address held");
    property p_area; rd_cfg |=> !(reg_rdata_o[15] && reg_rdata_o[9]); endproperty
    a_area: assert property (p_area) else $error("system area held");
    property p_msk;
        reg_wr_i && reg_addr_i == sdsw_pkg::REG_IRQ_MASK && reg_wdata_i[3:0] == 4'h0
            |=> !irq_o;
    endproperty
    a_msk: assert property (p_msk) else $error("masked irq high");
    c_full: cover property (rd_st && stn == 4'hF);
    c_irq: cover property (irq_o);
    c_rej: cover property (reg_wr_i && reg_addr_i == sdsw_pkg::REG_CFG && reg_wdata_i[10]);
endmodule // sdsw_assertions
bind sdsw_top sdsw_assertions u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .station_line_one_i(station_line_one_i), .station_line_two_i(station_line_two_i),
    .station_line_three_i(station_line_three_i), .station_line_four_i(station_line_four_i),
    .board_fault_i(board_fault_i), .host_comm_err_i(host_comm_err_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .box_present_o(box_present_o),
    .irq_o(irq_o));

// ===== tb/sdsw_box_model.sv
// Purpose: Removable box number switch seen on the station lines
// Assumes: Switch set to 1..15 while attached
// Notes: Detached box leaves every line OFF
`timescale 1ns/1ps
module sdsw_box_model (
    input wire logic mclk_i,
    input wire logic attach_i,
    input wire logic [3:0] stn_set_i,
    output logic line_one_o,
    output logic line_two_o,
    output logic line_three_o,
    output logic line_four_o
);
    wire logic [3:0] lv = attach_i ? stn_set_i : 4'h0;
    // Binary wiring, line one weight one
    always_ff @(posedge mclk_i) begin
        {line_four_o, line_three_o, line_two_o, line_one_o} <= lv;
    end
endmodule // sdsw_box_model

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the status word block
// Assumes: Register reads answered one cycle after the strobe
// Notes: Flags come from a fixed-seed LFSR; stations sweep 0..15, then come from it
`timescale 1ns/1ps
module testbench;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic attach = 1'b0;
    logic [3:0] cs = 4'h0;
    logic cb = 1'b0;
    logic ch = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] lfsr = 32'h545C;
    logic [15:0] got;
    logic [15:0] cw;
    wire logic l1, l2, l3, l4, box, irq;
    wire logic [15:0] rdata;
    int n_mismatch = 0;
    int checked = 0;
    always #50 mclk_i = ~mclk_i;
    sdsw_box_model u_box (.mclk_i(mclk_i), .attach_i(attach), .stn_set_i(cs),
        .line_one_o(l1), .line_two_o(l2), .line_three_o(l3), .line_four_o(l4));
    sdsw_top u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .station_line_one_i(l1),
        .station_line_two_i(l2), .station_line_three_i(l3), .station_line_four_i(l4),
        .board_fault_i(cb), .host_comm_err_i(ch), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .box_present_o(box),
        .irq_o(irq));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [15:0] word(input logic [3:0] s, input logic b, input logic h);
        return {b, h, 10'h000, s};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rreg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 got = rdata;
        @(posedge mclk_i);
    endtask
    task automatic summarize;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge mclk_i);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        rreg(sdsw_pkg::REG_CFG);
        check(got, 16'h0000, "cfg reset");
        for (int i = 0; i < 24; i++) begin
            lfsr = nxt(lfsr);
            cs <= (i < 16) ? i[3:0] : lfsr[5:2];
            attach <= (i < 16) ? (i != 0) : (lfsr[5:2] != 4'h0);
            cb <= lfsr[0];
            ch <= lfsr[1];
            repeat (6) @(posedge mclk_i);
            rreg(sdsw_pkg::REG_STATUS);
            check(got, word(cs, cb, ch), "status");
            check({15'h0000, box}, {15'h0000, cs != 4'h0}, "box");
        end
        attach <= 1'b0;
        cs <= 4'h9;
        repeat (6) @(posedge mclk_i);
        rreg(sdsw_pkg::REG_STATUS);
        check(got, word(4'h0, cb, ch), "detached");
        check({15'h0000, box}, 16'h0000, "no box");
        attach <= 1'b1;
        repeat (6) @(posedge mclk_i);
        wreg(sdsw_pkg::REG_STATUS, 16'h7FF0);
        rreg(sdsw_pkg::REG_STATUS);
        check(got, word(cs, cb, ch), "status ro");
        ch <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rreg(sdsw_pkg::REG_FLAGS);
        check(got, {14'h0, 1'b0, cb}, "flags");
        wreg(sdsw_pkg::REG_IRQ_MASK, 16'h0004);
        rreg(sdsw_pkg::REG_IRQ_STAT);
        ch <= 1'b1;
        repeat (4) @(posedge mclk_i);
        check({15'h0000, irq}, 16'h0001, "irq up");
        rreg(sdsw_pkg::REG_IRQ_STAT);
        check({12'h000, got[3:0]}, 16'h0004, "irq stat");
        check({15'h0000, irq}, 16'h0000, "irq clr");
        wreg(sdsw_pkg::REG_IRQ_MASK, 16'h0000);
        ch <= 1'b0;
        repeat (4) @(posedge mclk_i);
        ch <= 1'b1;
        repeat (4) @(posedge mclk_i);
        check({15'h0000, irq}, 16'h0000, "irq masked");
        wreg(sdsw_pkg::REG_IRQ_MASK, 16'h0003);
        rreg(sdsw_pkg::REG_IRQ_MASK);
        check(got, 16'h0003, "mask");
        cb <= 1'b0;
        repeat (6) @(posedge mclk_i);
        rreg(sdsw_pkg::REG_IRQ_STAT);
        check({15'h0000, irq}, 16'h0000, "irq idle");
        cb <= 1'b1;
        attach <= 1'b0;
        repeat (6) @(posedge mclk_i);
        check({15'h0000, irq}, 16'h0001, "irq evt");
        rreg(sdsw_pkg::REG_IRQ_STAT);
        check({12'h000, got[3:0]}, 16'h0003, "stn brd evt");
        attach <= 1'b1;
        wreg(sdsw_pkg::REG_CFG, 16'h8405);
        rreg(sdsw_pkg::REG_CFG);
        check(got, 16'h0000, "bit addr");
        rreg(sdsw_pkg::REG_IRQ_STAT);
        check({15'h0000, got[3]}, 16'h0001, "reject");
        wreg(sdsw_pkg::REG_CFG, 16'h8205);
        rreg(sdsw_pkg::REG_CFG);
        check(got, 16'h0000, "sys area");
        for (int k = 0; k < 2; k++) begin
            cw = k[0] ? 16'h8133 : 16'h8010;
            wreg(sdsw_pkg::REG_CFG, cw);
            rreg(sdsw_pkg::REG_CFG);
            check(got, cw, "cfg");
            wreg(sdsw_pkg::REG_MEM_ADDR, {7'h00, cw[8:0]});
            repeat (3) @(posedge mclk_i);
            rreg(sdsw_pkg::REG_MEM_DATA);
            check(got, word(cs, cb, ch), "mem word");
        end
        wreg(sdsw_pkg::REG_CFG, 16'h0000);
        cw = word(cs, cb, ch);
        cb <= ~cb;
        repeat (4) @(posedge mclk_i);
        rreg(sdsw_pkg::REG_MEM_DATA);
        check(got, cw, "mem frozen");
        wreg(8'h20, 16'hFFFF);
        rreg(8'h20);
        check(got, 16'h0000, "unmapped");
        summarize();
    end
endmodule // testbench
